// [hw/sfu_pkg.sv]
package sfu_pkg;
	localparam logic [7:0] OP_UNLOCK = 8'he9;
	localparam logic [7:0] OP_SW_RESET = 8'hf0;
	localparam logic [7:0] OP_MODE_RESET = 8'hff;
	localparam logic [7:0] OP_CLEAR_STATUS = 8'h30;
	localparam logic [7:0] OP_PPB_PROG = 8'he3;
	localparam logic [7:0] OP_PPB_ERASE = 8'he4;
	localparam logic [7:0] OP_PAGE_PROG = 8'h02;
	localparam logic [7:0] OP_SECTOR_ERASE = 8'hd8;
	localparam logic [7:0] OP_PROG_SUSP = 8'h85;
	localparam logic [7:0] OP_PROG_RES = 8'h8a;
	localparam logic [7:0] OP_ERASE_SUSP = 8'h75;
	localparam logic [7:0] OP_ERASE_RES = 8'h7a;
	localparam logic [6:0] OPCODE_BITS = 7'h08;
	localparam logic [6:0] UNLOCK_FRAME_BITS = 7'h48;
	localparam int PASSWORD_BITS = 64;
	// status register byte layout
	localparam int SR_WIP_POS = 0;
	localparam int SR_BP_LO_POS = 2;
	localparam int SR_P_ERR_POS = 6;
	// config register one layout
	localparam int CR1_LOCK_POS = 1;
	localparam int CR1_TOP_BOTTOM_PARAM_SEL_POS = 2;
	localparam int CR1_BLOCK_PROTECT_VOLATILITY_POS = 3;
	localparam int CR1_TOP_BOTTOM_PROTECT_SEL_POS = 5;
	localparam logic [7:0] SR_RESET = 8'h00;
	localparam logic [7:0] CR1_RESET = 8'h00;
	// timing
	localparam int CLK_MHZ = 100;
	localparam int PAGE_PROGRAM_TIME_US = 1480;
	localparam int SECTOR_ERASE_TIME_MS = 780;
	localparam int SUSPEND_LATENCY_US = 45;
	localparam int PAGE_PROGRAM_CYCLES = PAGE_PROGRAM_TIME_US * CLK_MHZ;
	localparam int SECTOR_ERASE_CYCLES = SECTOR_ERASE_TIME_MS * 1000 * CLK_MHZ;
	localparam int SUSPEND_LATENCY_CYCLES = SUSPEND_LATENCY_US * CLK_MHZ;
	localparam int UNLOCK_CYCLES = 100;
	localparam int RESET_RECOVERY_CYCLES = 100;

	typedef enum logic [2:0] {ST_IDLE, ST_UNLOCK, ST_LOCKERR, ST_OP, ST_SUSP_WAIT, ST_SUSPENDED,
		ST_RECOVER} sfu_state_t;

	// non-volatile settings loaded at hardware reset
	typedef struct packed {
		logic top_bottom_protect_sel;
		logic top_bottom_param_sel;
		logic block_protect_volatility;
		logic [2:0] block_protect;
		logic password_mode;
	} sfu_nv_t;

	// write of volatile bits from the register path
	typedef struct packed {
		logic valid;
		logic set_cfg_lock;
		logic [2:0] block_protect;
	} sfu_vol_wr_t;
endpackage

// [hw/sfu_cmd.sv]
`timescale 1ns/1ps
module sfu_cmd import sfu_pkg::*; #(
	parameter int unsigned PROG_CYCLES = PAGE_PROGRAM_CYCLES,
	parameter int unsigned ERASE_CYCLES = SECTOR_ERASE_CYCLES,
	parameter int unsigned SUSP_CYCLES = SUSPEND_LATENCY_CYCLES,
	parameter int unsigned UNLOCK_TIME = UNLOCK_CYCLES,
	parameter int unsigned RECOVERY_TIME = RESET_RECOVERY_CYCLES
) (
	input wire logic sys_clk_i, // core clock
	input wire logic rst_i, // hardware or power-on reset
	input wire logic link_sclk_i, // serial clock from host
	input wire logic link_cs_n_i, // chip select, active low
	input wire logic data_line_zero_i, // serial input
	input wire logic [63:0] hidden_password_i, // stored password
	input wire sfu_nv_t nv_i, // non-volatile settings
	input wire sfu_vol_wr_t vol_wr_i, // volatile bit write
	input wire logic perf_read_enter_i, // read path entered continuous mode
	output logic [7:0] status_reg_o, // status register
	output logic [7:0] config_reg_one_o, // config register one
	output logic protection_lock_bit_o, // protection lock
	output logic cont_read_o, // continuous read mode active
	output logic cmd_ready_o // accepting new commands
);
	// ****************************************
	// link side: shift in on serial clock
	// ****************************************
	typedef struct packed {
		logic [6:0] bit_cnt;
		logic [71:0] shreg;
	} sfu_link_t;

	sfu_link_t lnk, next_lnk;
	logic in_frame;

	// cleared by chip select; frame data stays frozen until the next frame's first edge
	always_ff @(posedge link_sclk_i or posedge link_cs_n_i) begin
		if (link_cs_n_i) begin
			in_frame <= 1'b0;
		end else begin
			in_frame <= 1'b1;
		end
	end

	always_comb begin
		next_lnk = lnk;
		if (!in_frame) begin
			next_lnk.bit_cnt = 7'h01;
		end else if (lnk.bit_cnt != 7'h7f) begin
			next_lnk.bit_cnt = lnk.bit_cnt + 7'h01;
		end
		next_lnk.shreg = {lnk.shreg[70:0], data_line_zero_i};
	end

	always_ff @(posedge link_sclk_i) begin
		lnk <= next_lnk;
	end

	// ****************************************
	// core side
	// ****************************************
	typedef struct packed {
		logic [2:0] cs_sync;
		sfu_state_t st;
		logic [31:0] wait_cnt;
		logic [31:0] op_left;
		logic op_erase;
		logic op_ppb;
		logic pw_ok;
		logic [7:0] sr;
		logic [7:0] cr1;
		logic prot_lock;
		logic cont_read;
		logic ready;
	} sfu_core_t;

	sfu_core_t s, next_s;
	logic take;
	logic len8;
	logic len72;
	logic [7:0] opcode;
	logic [63:0] pw;

	// link data is read only once chip select has been high for two core edges,
	// when the serial clock has stopped and the shift register is stable
	assign take = s.cs_sync[1] && !s.cs_sync[2];
	assign len8 = lnk.bit_cnt == OPCODE_BITS;
	assign len72 = lnk.bit_cnt == UNLOCK_FRAME_BITS;
	assign opcode = len72 ? lnk.shreg[71:64] : lnk.shreg[7:0];

	always_comb begin
		for (int b = 0; b < PASSWORD_BITS / 8; b++) begin
			pw[8*b +: 8] = lnk.shreg[63 - 8*b -: 8];
		end
	end

	always_comb begin
		next_s = s;
		next_s.cs_sync = {s.cs_sync[1:0], link_cs_n_i};
		if (perf_read_enter_i && s.st == ST_IDLE) begin
			next_s.cont_read = 1'b1;
		end
		if (vol_wr_i.valid && !s.cr1[CR1_LOCK_POS] && s.st == ST_IDLE) begin
			next_s.sr[SR_BP_LO_POS +: 3] = vol_wr_i.block_protect;
			next_s.cr1[CR1_LOCK_POS] = vol_wr_i.set_cfg_lock;
		end
		case (s.st)
			ST_UNLOCK: begin
				next_s.wait_cnt = s.wait_cnt - 32'h1;
				if (s.wait_cnt == 32'h1) begin
					if (s.pw_ok) begin
						next_s.prot_lock = 1'b1;
						next_s.sr[SR_WIP_POS] = 1'b0;
						next_s.st = ST_IDLE;
					end else begin
						next_s.sr[SR_P_ERR_POS] = 1'b1;
						next_s.st = ST_LOCKERR;
					end
				end
			end
			ST_OP: begin
				next_s.op_left = s.op_left - 32'h1;
				if (s.op_left == 32'h1) begin
					next_s.sr[SR_WIP_POS] = 1'b0;
					next_s.st = ST_IDLE;
				end
			end
			ST_SUSP_WAIT: begin
				// the op is frozen while it settles to a safe point
				next_s.wait_cnt = s.wait_cnt - 32'h1;
				if (s.wait_cnt == 32'h1) begin
					next_s.sr[SR_WIP_POS] = 1'b0;
					next_s.st = ST_SUSPENDED;
				end
			end
			ST_RECOVER: begin
				next_s.wait_cnt = s.wait_cnt - 32'h1;
				if (s.wait_cnt == 32'h1) begin
					next_s.st = ST_IDLE;
				end
			end
			default: begin
			end
		endcase
		if (take) begin
			if (s.cont_read) begin
				// only the mode reset is recognised in continuous read mode
				if (len8 && opcode == OP_MODE_RESET) begin
					next_s.cont_read = 1'b0;
				end
			end else if (len8 && opcode == OP_SW_RESET && s.st != ST_RECOVER) begin
				next_s.sr[SR_WIP_POS] = 1'b0;
				next_s.sr[SR_P_ERR_POS] = 1'b0;
				if (s.cr1[CR1_BLOCK_PROTECT_VOLATILITY_POS] && !s.cr1[CR1_LOCK_POS]) begin
					next_s.sr[SR_BP_LO_POS +: 3] = 3'h0;
				end
				next_s.st = ST_RECOVER;
				next_s.wait_cnt = 32'(RECOVERY_TIME);
			end else if (len8 && opcode == OP_CLEAR_STATUS && (s.st == ST_IDLE || s.st == ST_LOCKERR)) begin
				next_s.sr[SR_P_ERR_POS] = 1'b0;
				next_s.sr[SR_WIP_POS] = 1'b0;
				next_s.st = ST_IDLE;
			end else if (s.st == ST_IDLE) begin
				if (len72 && opcode == OP_UNLOCK) begin
					next_s.pw_ok = pw == hidden_password_i;
					next_s.sr[SR_WIP_POS] = 1'b1;
					next_s.wait_cnt = 32'(UNLOCK_TIME);
					next_s.st = ST_UNLOCK;
				end else if (len8 && (opcode == OP_PPB_PROG || opcode == OP_PAGE_PROG)) begin
					next_s.op_left = 32'(PROG_CYCLES);
					next_s.op_erase = 1'b0;
					next_s.op_ppb = opcode == OP_PPB_PROG;
					next_s.sr[SR_WIP_POS] = 1'b1;
					next_s.st = ST_OP;
				end else if (len8 && (opcode == OP_PPB_ERASE || opcode == OP_SECTOR_ERASE)) begin
					next_s.op_left = 32'(ERASE_CYCLES);
					next_s.op_erase = 1'b1;
					next_s.op_ppb = opcode == OP_PPB_ERASE;
					next_s.sr[SR_WIP_POS] = 1'b1;
					next_s.st = ST_OP;
				end
			end else if (s.st == ST_OP && len8) begin
				// protection-bit erase cannot be suspended
				if ((opcode == OP_PROG_SUSP && !s.op_erase) ||
					(opcode == OP_ERASE_SUSP && s.op_erase && !s.op_ppb)) begin
					next_s.wait_cnt = 32'(SUSP_CYCLES);
					next_s.st = ST_SUSP_WAIT;
				end
			end else if (s.st == ST_SUSPENDED && len8) begin
				if ((opcode == OP_PROG_RES && !s.op_erase) || (opcode == OP_ERASE_RES && s.op_erase)) begin
					next_s.sr[SR_WIP_POS] = 1'b1;
					next_s.st = ST_OP;
				end
			end
			// anything else in the stuck state falls through untouched
		end
		next_s.ready = next_s.st == ST_IDLE && !next_s.cont_read;
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			// hardware reset alone clears the config lock and restores protection lock
			s <= '0;
			s.cs_sync <= 3'h7;
			s.st <= ST_IDLE;
			s.sr <= SR_RESET;
			s.sr[SR_BP_LO_POS +: 3] <= nv_i.block_protect;
			s.cr1 <= CR1_RESET;
			s.cr1[CR1_TOP_BOTTOM_PROTECT_SEL_POS] <= nv_i.top_bottom_protect_sel;
			s.cr1[CR1_TOP_BOTTOM_PARAM_SEL_POS] <= nv_i.top_bottom_param_sel;
			s.cr1[CR1_BLOCK_PROTECT_VOLATILITY_POS] <= nv_i.block_protect_volatility;
			s.prot_lock <= !nv_i.password_mode;
			s.ready <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign status_reg_o = s.sr;
	assign config_reg_one_o = s.cr1;
	assign protection_lock_bit_o = s.prot_lock;
	assign cont_read_o = s.cont_read;
	assign cmd_ready_o = s.ready;

	// ****************************************
	// checks
	// ****************************************
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	// cycles spent settling toward a suspend; one check bounds it by the real latency, not the parameter
	logic [31:0] susp_age;
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || s.st != ST_SUSP_WAIT) begin
			susp_age <= 32'h0;
		end else begin
			susp_age <= susp_age + 32'h1;
		end
	end

	AST_UNLOCK_LEN: assert property (
		take && !s.cont_read && s.st == ST_IDLE && !len72 && !len8
		|=> s.st == ST_IDLE && !s.sr[SR_WIP_POS] && s.prot_lock == $past(s.prot_lock))
		else $error("unlock of wrong length was executed");
	AST_UNLOCK_START: assert property (
		take && !s.cont_read && s.st == ST_IDLE && len72 && opcode == OP_UNLOCK
		|=> s.sr[SR_WIP_POS] && s.st == ST_UNLOCK)
		else $error("unlock did not raise busy");
	AST_MISMATCH: assert property (
		s.st == ST_UNLOCK && s.wait_cnt == 32'h1 && !s.pw_ok && !take
		|=> s.sr[SR_P_ERR_POS] && s.sr[SR_WIP_POS] && s.st == ST_LOCKERR)
		else $error("mismatch did not set error with busy stuck");
	AST_STUCK: assert property (
		s.st == ST_LOCKERR && !(take && len8 && (opcode == OP_CLEAR_STATUS || opcode == OP_SW_RESET))
		|=> s.st == ST_LOCKERR && s.sr[SR_WIP_POS] && s.sr[SR_P_ERR_POS])
		else $error("stuck state left without clear or reset");
	AST_CLEAR: assert property (
		s.st == ST_LOCKERR && take && !s.cont_read && len8 && opcode == OP_CLEAR_STATUS
		|=> !s.sr[SR_WIP_POS] && !s.sr[SR_P_ERR_POS] ##1 s.st == ST_IDLE)
		else $error("clear status did not release stuck state");
	AST_MATCH: assert property (
		s.st == ST_UNLOCK && s.wait_cnt == 32'h1 && s.pw_ok && !take
		|=> s.prot_lock && !s.sr[SR_WIP_POS])
		else $error("match did not set protection lock");
	AST_SW_KEEP: assert property (
		take && !s.cont_read && len8 && opcode == OP_SW_RESET
		|=> s.prot_lock == $past(s.prot_lock) && s.cr1[CR1_LOCK_POS] == $past(s.cr1[CR1_LOCK_POS])
			&& s.cr1[CR1_TOP_BOTTOM_PROTECT_SEL_POS] == $past(s.cr1[CR1_TOP_BOTTOM_PROTECT_SEL_POS]))
		else $error("soft reset changed kept bits");
	AST_BP_CLEAR: assert property (
		take && !s.cont_read && len8 && opcode == OP_SW_RESET && s.st != ST_RECOVER
		&& s.cr1[CR1_BLOCK_PROTECT_VOLATILITY_POS] && !s.cr1[CR1_LOCK_POS]
		|=> s.sr[SR_BP_LO_POS +: 3] == 3'h0 && s.st == ST_RECOVER)
		else $error("soft reset did not clear volatile block protect");
	AST_SUSP_LAT: assert property (
		s.st == ST_SUSP_WAIT |-> susp_age < SUSP_CYCLES && s.sr[SR_WIP_POS])
		else $error("suspend latency exceeded");
	AST_MODE_RESET: assert property (
		take && s.cont_read && len8 && opcode == OP_MODE_RESET |=> !s.cont_read ##1 s.ready == (s.st == ST_IDLE))
		else $error("mode reset did not leave continuous read");
	AST_MODE_ONLY: assert property (
		take && s.cont_read && !(len8 && opcode == OP_MODE_RESET) |=> s.cont_read && s.st == ST_IDLE)
		else $error("command other than mode reset taken in continuous read");
	AST_READY: assert property (
		s.ready == (s.st == ST_IDLE && !s.cont_read))
		else $error("ready flag disagrees with state");
	AST_RECOVER_HOLD: assert property (
		s.st == ST_RECOVER && s.wait_cnt != 32'h1 |=> s.st == ST_RECOVER)
		else $error("command accepted during reset recovery");

	// ****************************************
	// checks: resets and timed operations
	// ****************************************
	AST_SW_CLEAR: assert property (
		take && !s.cont_read && len8 && opcode == OP_SW_RESET && s.st != ST_RECOVER
		|=> !s.sr[SR_WIP_POS] && !s.sr[SR_P_ERR_POS] && s.st == ST_RECOVER && !s.ready)
		else $error("soft reset did not clear busy and error");
	AST_SW_NV_KEEP: assert property (
		take && !s.cont_read && len8 && opcode == OP_SW_RESET
		|=> s.cr1[CR1_TOP_BOTTOM_PARAM_SEL_POS] == $past(s.cr1[CR1_TOP_BOTTOM_PARAM_SEL_POS])
			&& s.cr1[CR1_BLOCK_PROTECT_VOLATILITY_POS] == $past(s.cr1[CR1_BLOCK_PROTECT_VOLATILITY_POS]))
		else $error("soft reset changed a non-volatile select");
	AST_BP_KEEP: assert property (
		take && !s.cont_read && len8 && opcode == OP_SW_RESET && !vol_wr_i.valid
		&& (!s.cr1[CR1_BLOCK_PROTECT_VOLATILITY_POS] || s.cr1[CR1_LOCK_POS])
		|=> s.sr[SR_BP_LO_POS +: 3] == $past(s.sr[SR_BP_LO_POS +: 3]))
		else $error("soft reset cleared protected or non-volatile block protect");

	// neither lock may fall while the core runs; only the hardware reset branch clears them
	AST_LOCK_STICKY: assert property (
		s.prot_lock |=> s.prot_lock)
		else $error("protection lock fell without hardware reset");
	AST_CFG_LOCK_STICKY: assert property (
		s.cr1[CR1_LOCK_POS] |=> s.cr1[CR1_LOCK_POS])
		else $error("config lock fell without hardware reset");
	// reset values are only checkable with the default disable lifted
	AST_HW_RESET: assert property (
		disable iff (1'b0) rst_i |=> !s.cr1[CR1_LOCK_POS] && s.prot_lock == !nv_i.password_mode
			&& s.sr[SR_BP_LO_POS +: 3] == nv_i.block_protect && s.st == ST_IDLE && !s.cont_read)
		else $error("hardware reset did not restore power-up state");
	AST_UNLOCK_HOLD: assert property (
		s.st == ST_UNLOCK |-> s.sr[SR_WIP_POS])
		else $error("busy flag low during unlock");
	AST_CLEAR_IDLE: assert property (
		take && !s.cont_read && len8 && opcode == OP_CLEAR_STATUS && s.st == ST_IDLE
		|=> !s.sr[SR_P_ERR_POS] && !s.sr[SR_WIP_POS] && s.st == ST_IDLE)
		else $error("clear status in standby left a flag set");

	// protection-bit ops borrow the page-program and sector-erase counts
	AST_PPB_PROG_TIME: assert property (
		take && !s.cont_read && s.st == ST_IDLE && len8 && opcode == OP_PPB_PROG
		|=> s.st == ST_OP && s.sr[SR_WIP_POS] && s.op_left == 32'(PROG_CYCLES))
		else $error("protection-bit program not timed as a page program");
	AST_PPB_ERASE_TIME: assert property (
		take && !s.cont_read && s.st == ST_IDLE && len8 && opcode == OP_PPB_ERASE
		|=> s.st == ST_OP && s.sr[SR_WIP_POS] && s.op_left == 32'(ERASE_CYCLES))
		else $error("protection-bit erase not timed as a sector erase");
	AST_OP_DONE: assert property (
		s.st == ST_OP && s.op_left == 32'h1 && !take |=> s.st == ST_IDLE && !s.sr[SR_WIP_POS])
		else $error("timed operation overran its count");
	AST_SUSP_BOUND: assert property (
		s.st == ST_SUSP_WAIT |-> susp_age < 32'(SUSPEND_LATENCY_CYCLES))
		else $error("suspend latency beyond the allowed bound");
	AST_SUSP_DONE: assert property (
		s.st == ST_SUSPENDED |-> !s.sr[SR_WIP_POS])
		else $error("busy flag high while suspended");
endmodule

// [test/sfu_host.sv]
`timescale 1ns/1ps
module sfu_host (
	output logic sclk_o, // serial clock, still outside frames
	output logic cs_n_o, // chip select, active low
	output logic sdi_o // serial data to the device
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b0;
		sdi_o = 1'b0;
		// a clean rising edge of chip select clears the device's frame flag before the first frame
		#1 cs_n_o = 1'b1;
	end
	// ****************
	// frame driver
	// ****************
	// sends the n low bits of v msb first; half is the half period in ns
	task automatic send(input logic [71:0] v, input int n, input int half);
		cs_n_o = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			sdi_o = v[i];
			#(half) sclk_o = 1'b1;
			#(half) sclk_o = 1'b0;
		end
		#(half) cs_n_o = 1'b1;
		sdi_o = ~sdi_o; // released line must not keep the last bit
	endtask
endmodule

// [test/serial_flash_unlock_reset_cmds_tb.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module serial_flash_unlock_reset_cmds_tb;
	import sfu_pkg::*;
	localparam int PROG = 200;
	localparam int ERASE = 400;
	localparam int SUSP = 20;
	localparam logic [63:0] PW = 64'h0123456789abcdef;
	typedef struct packed {
		logic [71:0] frame;
		logic [6:0] nbits;
		logic mid_wip;
		logic [7:0] sr;
		logic [7:0] cr;
		logic lock;
	} sfu_row_t;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic link_sclk_i, link_cs_n_i, data_line_zero_i;
	sfu_vol_wr_t vol_wr_i = '0;
	logic perf_read_enter_i = 1'b0;
	logic [7:0] status_reg_o, config_reg_one_o;
	logic protection_lock_bit_o, cont_read_o, cmd_ready_o;
	int fail_count = 0;
	int comparisons = 0;
	int tick_count = 0;
	int n;
	sfu_row_t rows [7];
	always #5 sys_clk_i = ~sys_clk_i;
	sfu_host i_host (.sclk_o(link_sclk_i), .cs_n_o(link_cs_n_i), .sdi_o(data_line_zero_i));
	sfu_cmd #(.PROG_CYCLES(PROG), .ERASE_CYCLES(ERASE), .SUSP_CYCLES(SUSP), .UNLOCK_TIME(30),
		.RECOVERY_TIME(10)) i_dut (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.link_sclk_i(link_sclk_i),
		.link_cs_n_i(link_cs_n_i),
		.data_line_zero_i(data_line_zero_i),
		.hidden_password_i(PW),
		.nv_i(sfu_nv_t'{1'b1, 1'b1, 1'b1, 3'b101, 1'b1}),
		.vol_wr_i(vol_wr_i),
		.perf_read_enter_i(perf_read_enter_i),
		.status_reg_o(status_reg_o),
		.config_reg_one_o(config_reg_one_o),
		.protection_lock_bit_o(protection_lock_bit_o),
		.cont_read_o(cont_read_o),
		.cmd_ready_o(cmd_ready_o)
	);
	// ****************
	// helpers
	// ****************
	function automatic logic [71:0] unl(input logic [63:0] p);
		unl = {OP_UNLOCK, 64'h0};
		for (int b = 0; b < 8; b++) unl[63 - 8 * b -: 8] = p[8 * b +: 8];
	endfunction
	task automatic cyc(input int k);
		repeat (k) @(negedge sys_clk_i);
	endtask
	task automatic op(input logic [7:0] c);
		i_host.send({64'h0, c}, 8, 3);
	endtask
	task automatic wip_fall(input int lim);
		n = 0;
		while (status_reg_o[SR_WIP_POS] === 1'b1 && n < lim) begin
			cyc(1);
			n++;
		end
	endtask
	task automatic timed(input logic [7:0] c, input int exp);
		op(c);
		for (int k = 0; k < 20 && status_reg_o[SR_WIP_POS] !== 1'b1; k++) cyc(1);
		wip_fall(1000);
		`CHK((n >= exp - 2) && (n <= exp + 2), 1'b1)
	endtask
	task automatic susp(input logic [7:0] c, input logic [7:0] s, input logic [7:0] r);
		op(c);
		cyc(30);
		op(s);
		wip_fall(200);
		`CHK(n <= SUSP + 6, 1'b1)
		op(r);
		cyc(10); // resume to busy check gap kept generous
		`CHK(status_reg_o[SR_WIP_POS], 1'b1)
		wip_fall(1000);
		`CHK(status_reg_o[SR_WIP_POS], 1'b0)
	endtask
	task summarize;
		if (fail_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// ****************
	// watchdog
	// ****************
	always @(posedge sys_clk_i) begin
		tick_count++;
		if (tick_count == 20000) begin
			fail_count++;
			summarize();
		end
	end
	// ****************
	// main sequence
	// ****************
	initial begin
		rows[0] = '{unl(~PW), 7'd72, 1'b1, 8'h55, 8'h2c, 1'b0};
		rows[1] = '{unl(PW), 7'd72, 1'b1, 8'h55, 8'h2c, 1'b0};
		rows[2] = '{{64'h0, OP_CLEAR_STATUS}, 7'd8, 1'b0, 8'h14, 8'h2c, 1'b0};
		rows[3] = '{unl(PW) >> 1, 7'd71, 1'b0, 8'h14, 8'h2c, 1'b0};
		rows[4] = '{unl(PW), 7'd72, 1'b1, 8'h14, 8'h2c, 1'b1};
		rows[5] = '{{64'h0, OP_SW_RESET}, 7'd8, 1'b0, 8'h00, 8'h2c, 1'b1};
		rows[6] = '{{64'h0, OP_CLEAR_STATUS}, 7'd8, 1'b0, 8'h00, 8'h2c, 1'b1};
		cyc(6);
		rst_i = 1'b0;
		cyc(4);
		for (int r = 0; r < 7; r++) begin
			// unlock frames run slower to respect the link speed limit
			i_host.send(rows[r].frame, int'(rows[r].nbits), rows[r].nbits > 7'd8 ? 5 : 3);
			cyc(6);
			`CHK(status_reg_o[SR_WIP_POS], rows[r].mid_wip)
			cyc(60);
			`CHK(status_reg_o, rows[r].sr)
			`CHK(config_reg_one_o, rows[r].cr)
			`CHK(protection_lock_bit_o, rows[r].lock)
		end
		vol_wr_i = '{1'b1, 1'b1, 3'b011};
		cyc(1);
		vol_wr_i = '0;
		cyc(2);
		`CHK(config_reg_one_o, 8'h2e)
		op(OP_SW_RESET);
		cyc(6);
		`CHK(cmd_ready_o, 1'b0)
		cyc(30);
		`CHK(cmd_ready_o, 1'b1)
		`CHK(status_reg_o, 8'h0c)
		`CHK(config_reg_one_o, 8'h2e)
		`CHK(protection_lock_bit_o, 1'b1)
		rst_i = 1'b1;
		cyc(2);
		rst_i = 1'b0;
		cyc(2);
		`CHK(config_reg_one_o, 8'h2c)
		`CHK(status_reg_o, 8'h14)
		`CHK(protection_lock_bit_o, 1'b0)
		perf_read_enter_i = 1'b1;
		cyc(1);
		perf_read_enter_i = 1'b0;
		cyc(2);
		`CHK(cont_read_o, 1'b1)
		op(OP_SW_RESET);
		cyc(30);
		`CHK(cont_read_o, 1'b1)
		op(OP_MODE_RESET);
		cyc(10);
		`CHK(cont_read_o, 1'b0)
		`CHK(cmd_ready_o, 1'b1)
		timed(OP_PPB_PROG, PROG);
		timed(OP_PPB_ERASE, ERASE);
		susp(OP_PAGE_PROG, OP_PROG_SUSP, OP_PROG_RES);
		susp(OP_SECTOR_ERASE, OP_ERASE_SUSP, OP_ERASE_RES);
		summarize();
	end
endmodule
